// ===== hdl/pcs_sequencer.sv
// Function
// - Single-shot set performs one move from that set alone, then stops.
// - Ready drops when a move begins, returns when the whole chain ends.
// - Select and start arriving together are accepted; discrete host settles select first.
// - Select inputs decode as a binary data number; lowest bit alone selects 1.
// - Continuous-linked set proceeds to the next number without stopping.
// - Chain ends at the first single-shot or press-hold set.
// - At most four sets per chain, both linking kinds counted together.
// - Five or more sets in a requested chain raise the alarm at start.
// - Direction change inside a continuous chain raises the alarm while running.
// - Set 63 never chains on to set 0; it runs alone.
// - Continuous chain uses acceleration and deceleration of its starting set.
// - Press-hold set reached through a link runs at starting speed.
// - Dwell-linked set may reverse; pause for its dwell before the next set.
// - In-motion drops after each dwell-linked move, ready stays low meanwhile.
// - Dwell expiry starts the next move by itself and raises in-motion.
// - Data numbers 0 through 63 are selectable on six select inputs.
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`include "pcs_consts.svh"

module pcs_sequencer
    import pcs_pkg::*;
#(
    parameter int DWELL_TICK_CYC = `PCS_DWELL_TICK_CYC
) (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // Wishbone slave
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [`PCS_ADR_W-1:0]    wb_adr_i,
    input  wire logic [31:0]              wb_dat_i,
    input  wire logic [3:0]               wb_sel_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    // Host pins
    input  wire logic [`PCS_SET_W-1:0]    data_select_i,
    input  wire logic                     start_i,
    output logic                          ready_o,
    output logic                          in_motion_o,
    output logic                          alarm_o,
    // Trajectory generator
    output logic                          move_req_o,
    output pcs_move_s                     move_cmd_o,
    input  wire logic                     move_done_i
);

    localparam int NRD = `PCS_LOOK_N + 1;
    localparam int BUS_PORT = `PCS_LOOK_N;
    localparam int PW = $clog2(DWELL_TICK_CYC + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(DWELL_TICK_CYC - 1);

    // Link from e to the next number, never past the last set
    function automatic logic pcs_links(input pcs_entry_s e, input logic [`PCS_SET_W-1:0] set);
        pcs_links = ((e.func == PCS_FN_CONT) || (e.func == PCS_FN_DWELL)) && (set != `PCS_SET_LAST);
    endfunction

    // Sets in the chain from base, saturating at one past the limit
    function automatic logic [2:0] pcs_chain_len(input pcs_entry_s [`PCS_LOOK_N-1:0] e,
                                                 input logic [`PCS_SET_W-1:0] base);
        logic [2:0] len;
        logic       run;
        len = 3'd1;
        run = 1'b1;
        for (int k = 0; k < `PCS_LOOK_N - 1; k++) begin
            if (run && pcs_links(e[k], `PCS_SET_W'(base + `PCS_SET_W'(k)))) begin
                len = 3'(len + 3'd1);
            end else begin
                run = 1'b0;
            end
        end
        pcs_chain_len = len;
    endfunction

    function automatic pcs_move_s pcs_mk_move(input pcs_entry_s e, input logic [`PCS_SET_W-1:0] set,
                                             input logic [`PCS_SET_W-1:0] accel, input logic linked);
        pcs_move_s m;
        m.set         = set;
        m.accel_set   = accel;
        m.dir         = e.dir;
        m.func        = e.func;
        m.start_speed = linked && (e.func == PCS_FN_PRESS);
        pcs_mk_move = m;
    endfunction

    // Pin synchronisers
    logic [`PCS_SET_W-1:0] sel_s1_reg;
    logic [`PCS_SET_W-1:0] sel_s2_reg;
    logic                  start_s1_reg;
    logic                  start_s2_reg;
    logic                  start_d_reg;
    logic                  start_rise;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_s1_reg   <= `PCS_SET_RST;
            sel_s2_reg   <= `PCS_SET_RST;
            start_s1_reg <= 1'b0;
            start_s2_reg <= 1'b0;
            start_d_reg  <= 1'b0;
        end else begin
            sel_s1_reg   <= data_select_i;
            sel_s2_reg   <= sel_s1_reg;
            start_s1_reg <= start_i;
            start_s2_reg <= start_s1_reg;
            start_d_reg  <= start_s2_reg;
        end
    end

    // Select and start pass equal delays, so a same-update pair is taken together
    assign start_rise = start_s2_reg && !start_d_reg;

    // State
    pcs_state_e            state_reg,   state_next;
    logic [`PCS_SET_W-1:0] cur_reg,     cur_next;
    logic [`PCS_SET_W-1:0] accel_reg,   accel_next;
    logic [2:0]            len_reg,     len_next;
    logic [`PCS_DWELL_W-1:0] dwell_reg, dwell_next;
    logic [PW-1:0]         pre_reg,     pre_next;
    logic                  alarm_reg,   alarm_next;
    logic                  motion_reg,  motion_next;
    logic                  ready_reg,   ready_next;
    logic                  mreq_reg,    mreq_next;
    pcs_move_s             mcmd_reg,    mcmd_next;

    // Table access
    logic [`PCS_SET_W-1:0]                 look_base;
    logic [NRD-1:0][`PCS_SET_W-1:0]        rd_addr;
    pcs_entry_s [NRD-1:0]                  rd_ent;
    pcs_entry_s                            cur_ent;
    pcs_entry_s                            nxt_ent;
    logic [`PCS_SET_W-1:0]                 nxt_set;
    logic [2:0]                            look_len;
    logic                                  start_take;

    // Bus state
    logic                  ack_reg,  ack_next;
    logic [31:0]           dat_reg,  dat_next;
    logic [`PCS_SET_W-1:0] idx_reg,  idx_next;
    logic                  alm_clr;
    logic                  tbl_we;
    pcs_entry_s            tbl_wdata;
    logic                  bus_acc;

    // Binary data number from the synchronised pins (sel_s2_reg) while idle
    assign look_base = (state_reg == PCS_S_IDLE) ? sel_s2_reg : cur_reg;

    for (genvar g = 0; g < `PCS_LOOK_N; g++) begin : g_look
        assign rd_addr[g] = `PCS_SET_W'(look_base + `PCS_SET_W'(g));
    end
    assign rd_addr[BUS_PORT] = idx_reg;

    pcs_op_table #(
        .DEPTH (`PCS_SET_COUNT),
        .NRD   (NRD)
    ) u_table (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .we_i      (tbl_we),
        .waddr_i   (idx_reg),
        .wdata_i   (tbl_wdata),
        .rd_addr_i (rd_addr),
        .rd_data_o (rd_ent)
    );

    assign cur_ent    = rd_ent[0];
    assign nxt_ent    = rd_ent[1];
    assign nxt_set    = `PCS_SET_W'(cur_reg + 6'h01);
    assign look_len   = pcs_chain_len(rd_ent[`PCS_LOOK_N-1:0], look_base);
    assign start_take = (state_reg == PCS_S_IDLE) && start_rise && !alarm_reg;

    // Sequencer
    always_comb begin
        state_next  = state_reg;
        cur_next    = cur_reg;
        accel_next  = accel_reg;
        len_next    = len_reg;
        dwell_next  = dwell_reg;
        pre_next    = pre_reg;
        alarm_next  = alarm_reg;
        motion_next = motion_reg;
        mreq_next   = 1'b0;
        mcmd_next   = mcmd_reg;
        if (alm_clr) begin
            alarm_next = 1'b0;
        end
        unique case (state_reg)
            PCS_S_IDLE: begin
                if (start_take) begin
                    if (look_len > `PCS_CHAIN_MAX) begin
                        alarm_next = 1'b1;
                    end else begin
                        cur_next    = sel_s2_reg;
                        accel_next  = sel_s2_reg;
                        len_next    = look_len;
                        mcmd_next   = pcs_mk_move(cur_ent, sel_s2_reg, sel_s2_reg, 1'b0);
                        mreq_next   = 1'b1;
                        motion_next = 1'b1;
                        state_next  = PCS_S_MOVE;
                    end
                end
            end
            PCS_S_MOVE: begin
                if (move_done_i) begin
                    if (!pcs_links(cur_ent, cur_reg)) begin
                        motion_next = 1'b0;
                        state_next  = PCS_S_IDLE;
                    end else if (cur_ent.func == PCS_FN_CONT) begin
                        if (nxt_ent.dir != cur_ent.dir) begin
                            alarm_next  = 1'b1;
                            motion_next = 1'b0;
                            state_next  = PCS_S_IDLE;
                        end else begin
                            // No stop between sets; profile stays with the chain's start
                            cur_next  = nxt_set;
                            mcmd_next = pcs_mk_move(nxt_ent, nxt_set, accel_reg, 1'b1);
                            mreq_next = 1'b1;
                        end
                    end else begin
                        motion_next = 1'b0;
                        dwell_next  = cur_ent.dwell;
                        pre_next    = '0;
                        state_next  = PCS_S_WAIT;
                    end
                end
            end
            PCS_S_WAIT: begin
                if (dwell_reg == '0) begin
                    cur_next    = nxt_set;
                    accel_next  = nxt_set;
                    mcmd_next   = pcs_mk_move(nxt_ent, nxt_set, nxt_set, 1'b1);
                    mreq_next   = 1'b1;
                    motion_next = 1'b1;
                    state_next  = PCS_S_MOVE;
                end else if (pre_reg == PRE_LAST) begin
                    pre_next   = '0;
                    dwell_next = `PCS_DWELL_W'(dwell_reg - 16'h0001);
                end else begin
                    pre_next = PW'(pre_reg + 1'b1);
                end
            end
        endcase
        // Alarm holds ready low until software clears it
        ready_next = (state_next == PCS_S_IDLE) && !alarm_next;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg  <= PCS_S_IDLE;
            cur_reg    <= `PCS_SET_RST;
            accel_reg  <= `PCS_SET_RST;
            len_reg    <= 3'h0;
            dwell_reg  <= '0;
            pre_reg    <= '0;
            alarm_reg  <= 1'b0;
            motion_reg <= 1'b0;
            ready_reg  <= `PCS_READY_RST;
            mreq_reg   <= 1'b0;
            mcmd_reg   <= '0;
        end else begin
            state_reg  <= state_next;
            cur_reg    <= cur_next;
            accel_reg  <= accel_next;
            len_reg    <= len_next;
            dwell_reg  <= dwell_next;
            pre_reg    <= pre_next;
            alarm_reg  <= alarm_next;
            motion_reg <= motion_next;
            ready_reg  <= ready_next;
            mreq_reg   <= mreq_next;
            mcmd_reg   <= mcmd_next;
        end
    end

    // Register bus
    assign bus_acc = wb_cyc_i && wb_stb_i && !ack_reg;

    always_comb begin
        ack_next  = bus_acc;
        dat_next  = 32'h0;
        idx_next  = idx_reg;
        alm_clr   = 1'b0;
        tbl_we    = 1'b0;
        tbl_wdata = rd_ent[BUS_PORT];
        if (bus_acc && wb_we_i) begin
            unique case (wb_adr_i)
                `PCS_OFS_CTRL: begin
                    alm_clr = wb_sel_i[0] && wb_dat_i[`PCS_CTRL_ALM_CLR];
                end
                `PCS_OFS_TBL_IDX: begin
                    if (wb_sel_i[0]) begin
                        idx_next = wb_dat_i[`PCS_SET_W-1:0];
                    end
                end
                `PCS_OFS_TBL_DATA: begin
                    // Lanes not enabled keep the stored field
                    tbl_we = 1'b1;
                    if (wb_sel_i[0]) begin
                        tbl_wdata.func = pcs_func_e'(wb_dat_i[`PCS_TD_FUNC_LSB +: 2]);
                        tbl_wdata.dir  = wb_dat_i[`PCS_TD_DIR];
                    end
                    if (wb_sel_i[2]) begin
                        tbl_wdata.dwell[7:0] = wb_dat_i[`PCS_TD_DWELL_LSB +: 8];
                    end
                    if (wb_sel_i[3]) begin
                        tbl_wdata.dwell[15:8] = wb_dat_i[`PCS_TD_DWELL_LSB + 8 +: 8];
                    end
                end
                default: begin
                end
            endcase
        end else if (bus_acc) begin
            unique case (wb_adr_i)
                `PCS_OFS_STATUS: begin
                    dat_next[`PCS_STS_READY]                  = ready_reg;
                    dat_next[`PCS_STS_MOTION]                 = motion_reg;
                    dat_next[`PCS_STS_ALARM]                  = alarm_reg;
                    dat_next[`PCS_STS_SET_LSB +: `PCS_SET_W]  = cur_reg;
                    dat_next[`PCS_STS_LEN_LSB +: 3]           = len_reg;
                end
                `PCS_OFS_TBL_IDX: begin
                    dat_next[`PCS_SET_W-1:0] = idx_reg;
                end
                `PCS_OFS_TBL_DATA: begin
                    dat_next[`PCS_TD_FUNC_LSB +: 2]             = rd_ent[BUS_PORT].func;
                    dat_next[`PCS_TD_DIR]                       = rd_ent[BUS_PORT].dir;
                    dat_next[`PCS_TD_DWELL_LSB +: `PCS_DWELL_W] = rd_ent[BUS_PORT].dwell;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
            idx_reg <= `PCS_IDX_RST;
        end else begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
            idx_reg <= idx_next;
        end
    end

    assign wb_ack_o    = ack_reg;
    assign wb_dat_o    = dat_reg;
    assign ready_o     = ready_reg;
    assign in_motion_o = motion_reg;
    assign alarm_o     = alarm_reg;
    assign move_req_o  = mreq_reg;
    assign move_cmd_o  = mcmd_reg;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ready_drop;
        start_take && (look_len <= `PCS_CHAIN_MAX) |=> !ready_o && move_req_o && in_motion_o;
    endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("ready not dropped at move start");

    property p_single_stop;
        (state_reg == PCS_S_MOVE) && move_done_i && (cur_ent.func == PCS_FN_SINGLE)
            |=> (state_reg == PCS_S_IDLE) && !in_motion_o && !move_req_o;
    endproperty
    a_single_stop: assert property (p_single_stop) else $error("single-shot set did not stop");

    property p_sel_decode;
        start_take && (look_len <= `PCS_CHAIN_MAX) && (sel_s2_reg == 6'h01) |=> move_cmd_o.set == 6'h01;
    endproperty
    a_sel_decode: assert property (p_sel_decode) else $error("select bit 0 did not pick set 1");

    property p_cont_next;
        (state_reg == PCS_S_MOVE) && move_done_i && (cur_ent.func == PCS_FN_CONT)
            && (cur_reg != `PCS_SET_LAST) && (nxt_ent.dir == cur_ent.dir)
            |=> move_req_o && in_motion_o && (move_cmd_o.set == $past(nxt_set)) && !ready_o;
    endproperty
    a_cont_next: assert property (p_cont_next) else $error("continuous link did not proceed");

    property p_len_alarm;
        start_take && (look_len > `PCS_CHAIN_MAX) |=> alarm_o && !move_req_o && !in_motion_o;
    endproperty
    a_len_alarm: assert property (p_len_alarm) else $error("overlong chain not refused");

    property p_dir_alarm;
        (state_reg == PCS_S_MOVE) && move_done_i && (cur_ent.func == PCS_FN_CONT)
            && (cur_reg != `PCS_SET_LAST) && (nxt_ent.dir != cur_ent.dir)
            |=> alarm_o && !in_motion_o && !move_req_o;
    endproperty
    a_dir_alarm: assert property (p_dir_alarm) else $error("direction change not flagged");

    property p_last_alone;
        (state_reg == PCS_S_MOVE) && move_done_i && (cur_reg == `PCS_SET_LAST)
            |=> (state_reg == PCS_S_IDLE) && !move_req_o;
    endproperty
    a_last_alone: assert property (p_last_alone) else $error("set 63 chained onward");

    property p_accel_hold;
        move_req_o && ($past(state_reg) == PCS_S_MOVE) |-> move_cmd_o.accel_set == $past(accel_reg);
    endproperty
    a_accel_hold: assert property (p_accel_hold) else $error("profile changed inside chain");

    property p_press_speed;
        move_req_o |-> move_cmd_o.start_speed ==
            ((move_cmd_o.func == PCS_FN_PRESS) && ($past(state_reg) != PCS_S_IDLE));
    endproperty
    a_press_speed: assert property (p_press_speed) else $error("press-hold speed choice wrong");

    property p_dwell_pause;
        (state_reg == PCS_S_MOVE) && move_done_i && (cur_ent.func == PCS_FN_DWELL)
            && (cur_reg != `PCS_SET_LAST) |=> !in_motion_o && !ready_o ##1 !ready_o;
    endproperty
    a_dwell_pause: assert property (p_dwell_pause) else $error("dwell did not pause motion");

    property p_dwell_resume;
        (state_reg == PCS_S_WAIT) && (dwell_reg == '0)
            |=> move_req_o && in_motion_o && !ready_o && (move_cmd_o.set == $past(nxt_set));
    endproperty
    a_dwell_resume: assert property (p_dwell_resume) else $error("dwell expiry did not restart");

    c_single: cover property (start_take ##1 (state_reg == PCS_S_MOVE) [*2] ##[1:50] ready_o);
    c_cont:   cover property ((state_reg == PCS_S_MOVE) && move_done_i && (cur_ent.func == PCS_FN_CONT)
                              ##1 move_req_o);
    c_dwell:  cover property ((state_reg == PCS_S_WAIT) ##[1:1000] (move_req_o && in_motion_o));
    c_alarm:  cover property (start_take ##1 alarm_o);

endmodule

// ===== hdl/pcs_consts.svh
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

// Data numbers and chain limits
`define PCS_SET_W          6
`define PCS_SET_COUNT      64
`define PCS_SET_LAST       6'h3f
`define PCS_SET_RST        6'h00
`define PCS_CHAIN_MAX      3'd4
`define PCS_LOOK_N         5
`define PCS_DWELL_W        16

// Timing
`define PCS_CLK_PERIOD_NS  10
`define PCS_DWELL_TICK_US  1000
`define PCS_DWELL_TICK_CYC (`PCS_DWELL_TICK_US * 1000 / `PCS_CLK_PERIOD_NS)

// Register map (byte addresses)
`define PCS_ADR_W          8
`define PCS_OFS_CTRL       8'h00
`define PCS_OFS_STATUS     8'h04
`define PCS_OFS_TBL_IDX    8'h08
`define PCS_OFS_TBL_DATA   8'h0c

// Field positions
`define PCS_CTRL_ALM_CLR   0
`define PCS_STS_READY      0
`define PCS_STS_MOTION     1
`define PCS_STS_ALARM      2
`define PCS_STS_SET_LSB    8
`define PCS_STS_LEN_LSB    16
`define PCS_TD_FUNC_LSB    0
`define PCS_TD_DIR         2
`define PCS_TD_DWELL_LSB   16

// Reset values
`define PCS_READY_RST      1'b1
`define PCS_IDX_RST        6'h00

`endif

// ===== hdl/pcs_pkg.sv
`include "pcs_consts.svh"

package pcs_pkg;

    typedef enum logic [1:0] {
        PCS_FN_SINGLE = 2'h0,
        PCS_FN_CONT   = 2'h1,
        PCS_FN_DWELL  = 2'h2,
        PCS_FN_PRESS  = 2'h3
    } pcs_func_e;

    typedef enum logic [2:0] {
        PCS_S_IDLE = 3'h1,
        PCS_S_MOVE = 3'h2,
        PCS_S_WAIT = 3'h4
    } pcs_state_e;

    typedef struct packed {
        logic [`PCS_DWELL_W-1:0] dwell;
        logic                    dir;
        pcs_func_e               func;
    } pcs_entry_s;

    typedef struct packed {
        logic [`PCS_SET_W-1:0] set;
        logic [`PCS_SET_W-1:0] accel_set;
        logic                  dir;
        pcs_func_e             func;
        logic                  start_speed;
    } pcs_move_s;

endpackage

// ===== hdl/pcs_op_table.sv
`timescale 1ns/10ps
`include "pcs_consts.svh"

module pcs_op_table
    import pcs_pkg::*;
#(
    parameter int DEPTH = `PCS_SET_COUNT,
    parameter int NRD   = `PCS_LOOK_N + 1
) (
    // Clock and reset
    input  wire logic                                clk_i,
    input  wire logic                                rst_i,
    // Write port
    input  wire logic                                we_i,
    input  wire logic [`PCS_SET_W-1:0]               waddr_i,
    input  pcs_entry_s                               wdata_i,
    // Read ports
    input  wire logic [NRD-1:0][`PCS_SET_W-1:0]      rd_addr_i,
    output pcs_entry_s [NRD-1:0]                     rd_data_o
);

    pcs_entry_s mem_reg  [DEPTH];
    pcs_entry_s mem_next [DEPTH];

    always_comb begin
        mem_next = mem_reg;
        if (we_i) begin
            mem_next[waddr_i] = wdata_i;
        end
    end

    // Cleared table means every set is a lone move with no dwell
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else begin
            mem_reg <= mem_next;
        end
    end

    for (genvar g = 0; g < NRD; g++) begin : g_rd
        assign rd_data_o[g] = mem_reg[rd_addr_i[g]];
    end

endmodule

// ===== sim/pcs_traj_model.sv
`timescale 1ns/10ps

module pcs_traj_model #(
    parameter int DLY = 6
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Command side
    input  wire logic move_req_i,
    output logic      move_done_o
);
    int cnt;

    // One done pulse per request, after a fixed travel time
    always_ff @(posedge clk_i) begin
        move_done_o <= 1'b0;
        if (rst_i) begin
            cnt <= 0;
        end else if (move_req_i) begin
            cnt <= DLY;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            move_done_o <= (cnt == 1);
        end
    end
endmodule

// ===== sim/testbench.sv
`timescale 1ns/10ps

module testbench;
    import pcs_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, start = 0;
    logic done, rdy, mot, alm, req, ack;
    logic [7:0] adr = 0;
    logic [31:0] wd = 0, rdat, rd;
    logic [5:0] sel_n = 0;
    pcs_move_s cmd, q[$];
    int bad_count = 0, samples_checked = 0, gap = 0;

    always #5 clk_i = ~clk_i;

    pcs_sequencer #(.DWELL_TICK_CYC(4)) u_pcs_sequencer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(4'hf), .wb_dat_o(rdat),
        .wb_ack_o(ack), .data_select_i(sel_n), .start_i(start), .ready_o(rdy), .in_motion_o(mot),
        .alarm_o(alm), .move_req_o(req), .move_cmd_o(cmd), .move_done_i(done));
    pcs_traj_model u_pcs_traj_model (.clk_i(clk_i), .rst_i(rst_i), .move_req_i(req), .move_done_o(done));

    // Log every issued move and every stopped-but-busy cycle
    always @(posedge clk_i) begin
        if (req === 1'b1)
            q.push_back(cmd);
        if (rdy === 1'b0 && mot === 1'b0)
            gap++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wait_on(ref logic s, input logic v);
        int n;
        for (n = 0; n < 300 && s !== v; n++)
            @(posedge clk_i) #1;
        if (s !== v) begin
            bad_count++;
            report_and_stop();
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1;
        we <= w;
        adr <= a;
        wd <= d;
        wait_on(ack, 1);
        rd = rdat;
        @(posedge clk_i);
        cyc <= 0;
    endtask

    task automatic ent(input int n, input pcs_func_e f, input logic dir, input logic [15:0] dw);
        wb(1, 8'h08, 32'(n));
        wb(1, 8'h0c, {dw, 13'h0, dir, f});
    endtask

    // Select and start change together, start held until ready falls
    task automatic run(input logic [5:0] n, input logic al);
        q.delete();
        gap = 0;
        wait_on(rdy, 1);
        @(posedge clk_i);
        sel_n <= n;
        start <= 1;
        wait_on(rdy, 0);
        @(posedge clk_i);
        start <= 0;
        if (al) begin
            wait_on(alm, 1);
            wb(1, 8'h00, 32'h1);
        end
        wait_on(rdy, 1);
    endtask

    function automatic logic [31:0] mk(input int s, input int a, input logic d, input pcs_func_e f, input logic p);
        return 32'({6'(s), 6'(a), d, f, p});
    endfunction

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i) #1;
        check(32'({rdy, mot, alm}), 32'h4);
        wb(0, 8'h04, 0);
        check(rd, 32'h1);
        wb(0, 8'h40, 0);
        check(rd, 32'h0);
        run(0, 0);
        check(32'(q.size()), 1);
        check(32'(q[0]), mk(0, 0, 0, PCS_FN_SINGLE, 0));
        for (int i = 1; i < 4; i++)
            ent(i, PCS_FN_CONT, 0, 0);
        run(1, 0);
        check(32'(q.size()), 4);
        for (int i = 1; i < 4; i++)
            check(32'(q[i - 1]), mk(i, 1, 0, PCS_FN_CONT, 0));
        check(32'(q[3]), mk(4, 1, 0, PCS_FN_SINGLE, 0));
        check(32'(gap), 0);
        wb(0, 8'h04, 0);
        check(rd, 32'h40401);
        for (int i = 10; i < 14; i++)
            ent(i, PCS_FN_CONT, 0, 0);
        run(10, 1);
        check(32'(q.size()), 0);
        ent(40, PCS_FN_CONT, 0, 0);
        ent(41, PCS_FN_SINGLE, 1, 0);
        run(40, 1);
        check(32'(q.size()), 1);
        ent(63, PCS_FN_CONT, 0, 0);
        run(63, 0);
        check(32'(q.size()), 1);
        check(32'(q[0]), mk(63, 63, 0, PCS_FN_CONT, 0));
        ent(30, PCS_FN_DWELL, 0, 16'h1);
        wb(0, 8'h0c, 0);
        check(rd, 32'h10002);
        ent(31, PCS_FN_CONT, 1, 0);
        ent(32, PCS_FN_PRESS, 1, 0);
        run(30, 0);
        check(32'(q.size()), 3);
        check(32'(q[0]), mk(30, 30, 0, PCS_FN_DWELL, 0));
        check(32'(q[1]), mk(31, 31, 1, PCS_FN_CONT, 0));
        check(32'(q[2]), mk(32, 31, 1, PCS_FN_PRESS, 1));
        check(32'(gap), 32'd5);
        report_and_stop();
    end
endmodule
